// ===== hw/cfps_byte_shift.sv
`timescale 1ns/1ns
`default_nettype none
module cfps_byte_shift (
  input  wire logic       mclk,
  input  wire logic       rst_sync_n,
  input  wire logic       shift_start,
  input  wire logic [7:0] shift_tx,
  input  wire logic       si_sync,
  output logic            shift_done,
  output logic [7:0]      shift_rx,
  output logic            sck,
  output logic            so
);
  import cfps_pkg::*;

  logic       active;   // byte in progress
  logic [2:0] div;      // half-period divider
  logic [3:0] bits_left; // bits still to clock
  logic [7:0] shreg;    // out on msb, in on lsb

  ////////////////////////////////////////////////////////////////////////////
  // one byte, msb first: data changes on the falling edge, sampled on rising.
  // sck idles high so the device sees no edge between bytes.
  // si arrives two cycles late through the synchroniser; the half period of
  // four cycles leaves the device two cycles of output delay.
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      active     <= 1'b0;
      div        <= 3'h0;
      bits_left  <= 4'h0;
      shreg      <= 8'h00;
      shift_done <= 1'b0;
      shift_rx   <= 8'h00;
      sck        <= 1'b1;
      so         <= 1'b1;
    end else begin
      shift_done <= 1'b0;
      if (!active) begin
        div <= 3'h0;
        // start ignored while a byte is in flight
        if (shift_start) begin
          active    <= 1'b1;
          shreg     <= shift_tx;
          bits_left <= SHIFT_BITS;
        end
      end else if (div == SCK_HALF_CYC - 3'h1) begin
        div <= 3'h0;
        if (sck) begin
          // falling edge: present next bit
          sck <= 1'b0;
          so  <= shreg[7];
        end else begin
          // rising edge: take the device bit
          sck       <= 1'b1;
          shreg     <= {shreg[6:0], si_sync};
          bits_left <= bits_left - 4'h1;
          if (bits_left == 4'h1) begin
            active     <= 1'b0;
            shift_done <= 1'b1;
            shift_rx   <= {shreg[6:0], si_sync};
          end
        end
      end else begin
        div <= div + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/cfps_pkg.sv
`default_nettype none
package cfps_pkg;
  // clock rate and link timing
  localparam int unsigned MCLK_MHZ       = 20;           // mclk frequency in MHz
  localparam logic [2:0]  SCK_HALF_CYC   = 3'h4;         // mclk cycles per sck half period
  localparam logic [3:0]  SHIFT_BITS     = 4'h8;         // bits per link byte

  // frame framing bytes
  localparam logic [7:0]  FRAME_SOH      = 8'h01;        // command frame start
  localparam logic [7:0]  FRAME_STX      = 8'h02;        // status frame start
  localparam logic [7:0]  FRAME_ETX      = 8'h03;        // frame end marker
  localparam logic [7:0]  RX_FILL        = 8'h00;        // byte clocked out while receiving

  // primary status codes returned by the device
  localparam logic [7:0]  ST_CMD_ERR     = 8'h04;        // R5
  localparam logic [7:0]  ST_PARAM_ERR   = 8'h05;        // R5
  localparam logic [7:0]  ST_ACK         = 8'h06;
  localparam logic [7:0]  ST_SUM_ERR     = 8'h07;        // R5
  localparam logic [7:0]  ST_VERIFY_ERR  = 8'h0F;        // R6
  localparam logic [7:0]  ST_PROTECT_ERR = 8'h10;        // R6
  localparam logic [7:0]  ST_NACK        = 8'h15;        // R6
  localparam logic [7:0]  ST_MODE_PIN_WRITE_FAULT = 8'h18; // R7
  localparam logic [7:0]  ST_ERASE_MARGIN_FAULT   = 8'h1A; // R7
  localparam logic [7:0]  ST_VERIFY_MARGIN_FAULT  = 8'h1B; // R7
  localparam logic [7:0]  ST_WRITE_ERR   = 8'h1C;        // R7
  localparam logic [7:0]  ST_BUSY        = 8'hFF;        // busy code, plain default

  // command codes, plain defaults
  localparam logic [7:0]  COM_STATUS     = 8'h70;
  localparam logic [7:0]  COM_RESET      = 8'h00;
  localparam logic [7:0]  COM_FREQ_SET   = 8'h90;

  // frame length field values
  localparam logic [7:0]  LENGTH_SHORT    = 8'h01;       // command code only
  localparam logic [7:0]  LENGTH_FREQ_SET = 8'h05;       // R17

  // frequency parameter bytes carried by the frequency-set frame: 8 MHz
  localparam logic [31:0] FREQ_PARAM_8MHZ = 32'h0800_0000; // R14

  // status frame reception
  localparam logic [3:0]  RX_LAST_IDX    = 4'h5;         // start, length, two codes, sum, end
  localparam logic [3:0]  CODE_IDX       = 4'h2;         // position of primary status code
  localparam logic [3:0]  PRM_FIRST_IDX  = 4'h3;         // first parameter byte position

  // reset retries
  localparam logic [4:0]  RESET_MAX_ATTEMPTS = 5'h10;    // R10

  typedef enum logic [1:0] {
    CMD_STATUS   = 2'b00,
    CMD_RESET    = 2'b01,
    CMD_FREQ_SET = 2'b10
  } cfps_cmd_type;

  typedef enum logic [1:0] {
    RES_NORMAL   = 2'b00,
    RES_ABNORMAL = 2'b01,
    RES_TIMEOUT  = 2'b10
  } cfps_result_type;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SPACE = 3'b001,
    S_SEND  = 3'b010,
    S_DELAY = 3'b011,
    S_RECV  = 3'b100,
    S_CHECK = 3'b101
  } cfps_state_type;
endpackage
`default_nettype wire

// ===== hw/cfps_sequencer.sv
// How it works
// [R1] status frame sent, wait, then read status
// [R2] acknowledge code means normal completion
// [R3] busy: resend status until limit, then time-out
// [R4] other codes abort, code kept
// [R5] device codes 04H, 05H, 07H
// [R6] device codes 0FH, 10H, 15H
// [R7] device codes 18H, 1AH, 1BH, 1CH
// [R8] spacing wait before reset or frequency frame
// [R9] reset: response delay, then status polling
// [R10] reset retried, sixteen attempts at most
// [R11] acknowledge to reset means synchronised
// [R12] device flags bad checksum, length, end marker
// [R13] time-out after reset ends without retry
// [R14] frequency frame, if sent, carries 8 MHz
// [R15] frequency: response delay, poll, report outcome
// [R16] device rejects out-of-range frequency with 05H
// [R17] frequency frame carries four parameter bytes
`timescale 1ns/1ns
`default_nettype none
module cfps_sequencer #(
  parameter int unsigned COMMAND_SPACING_US       = 100,   // spacing before a reset or frequency command
  parameter int unsigned STATUS_FRAME_DELAY_US    = 100,   // status command to status read
  parameter int unsigned RESET_RESPONSE_DELAY_US  = 1000,  // reset frame to first poll
  parameter int unsigned FREQ_SET_RESPONSE_DELAY_US = 1000, // frequency frame to first poll
  parameter int unsigned STATUS_LIMIT_US          = 10000, // busy limit, plain status
  parameter int unsigned RESET_LIMIT_US           = 10000, // busy limit after reset
  parameter int unsigned FREQ_SET_LIMIT_US        = 10000  // busy limit after frequency set
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       start,
  input  wire cfps_pkg::cfps_cmd_type     cmd_sel,
  output logic                            busy,
  output logic                            done,
  output var cfps_pkg::cfps_result_type   result,
  output logic [7:0]                      primary_status_code,
  output logic [4:0]                      attempt_count,
  output logic                            sck,
  output logic                            so,
  input  wire logic                       si
);
  import cfps_pkg::*;

  // every wait is a least time, exact in whole cycles, never below one
  localparam int unsigned TCOM_CYC  = (COMMAND_SPACING_US * MCLK_MHZ > 0) ?
                                      COMMAND_SPACING_US * MCLK_MHZ : 1;
  localparam int unsigned TSF_CYC   = (STATUS_FRAME_DELAY_US * MCLK_MHZ > 0) ?
                                      STATUS_FRAME_DELAY_US * MCLK_MHZ : 1;
  localparam int unsigned TRST_CYC  = (RESET_RESPONSE_DELAY_US * MCLK_MHZ > 0) ?
                                      RESET_RESPONSE_DELAY_US * MCLK_MHZ : 1;
  localparam int unsigned TFREQ_CYC = (FREQ_SET_RESPONSE_DELAY_US * MCLK_MHZ > 0) ?
                                      FREQ_SET_RESPONSE_DELAY_US * MCLK_MHZ : 1;
  localparam int unsigned LST_CYC   = STATUS_LIMIT_US * MCLK_MHZ;
  localparam int unsigned LRST_CYC  = RESET_LIMIT_US * MCLK_MHZ;
  localparam int unsigned LFREQ_CYC = FREQ_SET_LIMIT_US * MCLK_MHZ;

  logic            rst_meta_n;    // reset release, first stage
  logic            rst_sync_n;    // reset used by the design
  logic            si_meta;       // data in, first stage, read only by si_sync
  logic            si_sync;       // data in, safe to read
  cfps_state_type  state;         // sequencer state
  cfps_cmd_type    cmd;           // command being run
  logic            poll_phase;    // 0: command frame, 1: status polling
  logic [3:0]      idx;           // byte index within frame
  logic            inflight;      // byte handed to shifter
  logic [31:0]     wait_cnt;      // down counter for spacing and delays
  logic [31:0]     poll_timer;    // time since polling began
  logic            shift_start;   // one-cycle start to shifter
  logic [7:0]      shift_tx;      // byte to send
  logic            shift_done;    // byte finished
  logic [7:0]      shift_rx;      // byte received
  logic [7:0]      cur_com;       // command code of current frame
  logic [7:0]      cur_len;       // frame length field of current frame
  logic [31:0]     cur_prm;       // frequency parameter bytes
  logic [7:0]      cur_sum;       // checksum of current frame
  logic [31:0]     limit_cyc;     // busy limit for the command
  logic            limit_over;    // busy limit expired
  logic            poll_begin;    // polling starts this cycle
  logic [7:0]      next_byte;     // byte at idx of current frame

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // si is driven off the device's view of sck, so it is asynchronous here
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      si_meta <= 1'b1;
      si_sync <= 1'b1;
    end else begin
      si_meta <= si;
      si_sync <= si_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame contents: SOH, length field, command, parameters, checksum, ETX
  always_comb begin
    cur_prm = FREQ_PARAM_8MHZ;                          // R14
    if (poll_phase || cmd == CMD_STATUS) begin
      cur_com = COM_STATUS;
      cur_len = LENGTH_SHORT;
    end else if (cmd == CMD_RESET) begin
      cur_com = COM_RESET;
      cur_len = LENGTH_SHORT;
    end else begin
      cur_com = COM_FREQ_SET;
      cur_len = LENGTH_FREQ_SET;                        // R17
    end
    // two's complement of the byte sum, so the device sees no checksum fault
    cur_sum = 8'h00 - cur_len - cur_com;                // R12
    if (cur_len == LENGTH_FREQ_SET) begin
      cur_sum = cur_sum - cur_prm[31:24] - cur_prm[23:16] - cur_prm[15:8] - cur_prm[7:0];
    end
  end

  always_comb begin
    if (idx == 4'h0) begin
      next_byte = FRAME_SOH;
    end else if (idx == 4'h1) begin
      next_byte = cur_len;
    end else if (idx == 4'h2) begin
      next_byte = cur_com;
    end else if ({4'h0, idx} < cur_len + 8'h02) begin
      // parameter bytes, first one most significant
      case (2'(idx - PRM_FIRST_IDX))
        2'b00:   next_byte = cur_prm[31:24];
        2'b01:   next_byte = cur_prm[23:16];
        2'b10:   next_byte = cur_prm[15:8];
        default: next_byte = cur_prm[7:0];
      endcase
    end else if ({4'h0, idx} == cur_len + 8'h02) begin
      next_byte = cur_sum;
    end else begin
      next_byte = FRAME_ETX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy time limit, chosen per command
  always_comb begin
    case (cmd)
      CMD_RESET:    limit_cyc = LRST_CYC;
      CMD_FREQ_SET: limit_cyc = LFREQ_CYC;
      default:      limit_cyc = LST_CYC;
    endcase
  end

  assign limit_over = (poll_timer >= limit_cyc);
  assign poll_begin = (state == S_DELAY) && (wait_cnt == 32'h0000_0000) && !poll_phase;

  // limit runs from the first status command of a poll, saturating
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      poll_timer <= 32'h0000_0000;
    end else if (state == S_IDLE || poll_begin) begin
      poll_timer <= 32'h0000_0000;
    end else if (poll_timer != 32'hFFFF_FFFF) begin
      poll_timer <= poll_timer + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state               <= S_IDLE;
      cmd                 <= CMD_STATUS;
      poll_phase          <= 1'b0;
      idx                 <= 4'h0;
      inflight            <= 1'b0;
      wait_cnt            <= 32'h0000_0000;
      shift_start         <= 1'b0;
      shift_tx            <= 8'h00;
      busy                <= 1'b0;
      done                <= 1'b0;
      result              <= RES_NORMAL;
      primary_status_code <= 8'h00;
      attempt_count       <= 5'h00;
    end else begin
      shift_start <= 1'b0;
      done        <= 1'b0;
      case (state)
        S_IDLE: begin
          // start ignored while busy
          if (start) begin
            busy          <= 1'b1;
            cmd           <= cmd_sel;
            idx           <= 4'h0;
            attempt_count <= 5'h01;
            if (cmd_sel == CMD_STATUS) begin
              poll_phase <= 1'b1;                       // R1
              state      <= S_SEND;
            end else begin
              poll_phase <= 1'b0;
              wait_cnt   <= 32'(TCOM_CYC - 1);          // R8
              state      <= S_SPACE;
            end
          end
        end
        S_SPACE: begin
          if (wait_cnt == 32'h0000_0000) begin
            state <= S_SEND;                            // R8
          end else begin
            wait_cnt <= wait_cnt - 32'h0000_0001;
          end
        end
        S_SEND: begin
          if (!inflight) begin
            shift_start <= 1'b1;
            shift_tx    <= next_byte;
            inflight    <= 1'b1;
          end else if (shift_done) begin
            inflight <= 1'b0;
            if ({4'h0, idx} == cur_len + 8'h03) begin
              idx   <= 4'h0;
              state <= S_DELAY;
              if (poll_phase) begin
                wait_cnt <= 32'(TSF_CYC - 1);           // R1
              end else if (cmd == CMD_RESET) begin
                wait_cnt <= 32'(TRST_CYC - 1);          // R9
              end else begin
                wait_cnt <= 32'(TFREQ_CYC - 1);         // R15
              end
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        S_DELAY: begin
          if (wait_cnt != 32'h0000_0000) begin
            wait_cnt <= wait_cnt - 32'h0000_0001;
          end else if (!poll_phase) begin
            // response delay over: status polling begins
            poll_phase <= 1'b1;                         // R9
            state      <= S_SEND;
          end else begin
            state <= S_RECV;                            // R1
          end
        end
        S_RECV: begin
          if (!inflight) begin
            shift_start <= 1'b1;
            shift_tx    <= RX_FILL;
            inflight    <= 1'b1;
          end else if (shift_done) begin
            inflight <= 1'b0;
            if (idx == CODE_IDX) begin
              primary_status_code <= shift_rx;          // R4
            end
            if (idx == RX_LAST_IDX) begin
              idx   <= 4'h0;
              state <= S_CHECK;
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        S_CHECK: begin
          if (primary_status_code == ST_ACK) begin
            // for reset this also marks the link synchronised
            result <= RES_NORMAL;                       // R2 R11
            done   <= 1'b1;
            busy   <= 1'b0;
            state  <= S_IDLE;
          end else if (primary_status_code == ST_BUSY) begin
            if (limit_over) begin
              // after reset a time-out is final, never retried
              result <= RES_TIMEOUT;                    // R3 R13
              done   <= 1'b1;
              busy   <= 1'b0;
              state  <= S_IDLE;
            end else begin
              state <= S_SEND;                          // R3
            end
          end else if (cmd == CMD_RESET && attempt_count < RESET_MAX_ATTEMPTS) begin
            attempt_count <= attempt_count + 5'h01;     // R10
            poll_phase    <= 1'b0;
            wait_cnt      <= 32'(TCOM_CYC - 1);
            state         <= S_SPACE;
          end else begin
            result <= RES_ABNORMAL;                     // R4 R10 R15
            done   <= 1'b1;
            busy   <= 1'b0;
            state  <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte shifter on the serial link
  cfps_byte_shift u_shift (
    .mclk        (mclk),
    .rst_sync_n  (rst_sync_n),
    .shift_start (shift_start),
    .shift_tx    (shift_tx),
    .si_sync     (si_sync),
    .shift_done  (shift_done),
    .shift_rx    (shift_rx),
    .sck         (sck),
    .so          (so)
  );
endmodule
`default_nettype wire

// ===== verification/cfps_flash_dev.sv
`timescale 1ns/1ns
`default_nettype none
module cfps_flash_dev (
  input  wire logic sck,
  input  wire logic so,
  output logic      si
);
  import cfps_pkg::*;
  logic [7:0] script[$]; // codes the bench wants served, in order
  logic [7:0] frame[$];  // command frame being received
  logic [7:0] resp[$];   // status frame bytes still to shift out
  logic [7:0] rx_byte;   // incoming shift register
  logic [7:0] pend;      // outcome of the last non-status frame
  logic [7:0] err;       // fault found in the current frame
  logic [7:0] code;      // status code to return
  logic [7:0] sum;       // running checksum
  int         bit_cnt;   // bit position within the byte
  initial begin
    si = 1'b1;
    bit_cnt = 0;
    pend = 8'h00;
    rx_byte = 8'h00;
  end
  ////////////////////////////////////////
  // drive after the fall; when released toggle so a stale bit never looks valid
  always @(negedge sck) begin
    if (resp.size() > 0) si <= #20 resp[0][7 - bit_cnt];
    else si <= #20 ~si;
  end
  ////////////////////////////////////////
  // sample on the rise, decode a frame once its length is complete
  // a fall must come first, so sck rising out of reset is never taken as a bit
  always begin
    @(negedge sck);
    @(posedge sck);
    rx_byte = {rx_byte[6:0], so};
    bit_cnt++;
    if (bit_cnt == 8) begin
      bit_cnt = 0;
      if (resp.size() > 0) begin
        void'(resp.pop_front());
      end else begin
        frame.push_back(rx_byte);
        if (frame.size() > 1 && frame.size() == int'(frame[1]) + 4) begin
          sum = 8'h00;
          for (int k = 1; k < frame.size() - 1; k++) sum = sum + frame[k];
          err = 8'h00;
          if (sum != 8'h00) err = ST_SUM_ERR;
          else if (frame[frame.size() - 1] != FRAME_ETX) err = ST_NACK;
          else if (frame[2] == COM_FREQ_SET && frame[1] != 8'h05) err = ST_NACK;
          else if (frame[2] == COM_FREQ_SET
                   && {frame[3], frame[4], frame[5], frame[6]} != 32'h0800_0000)
            err = ST_PARAM_ERR;
          else if (!(frame[2] inside {COM_STATUS, COM_RESET, COM_FREQ_SET}))
            err = ST_CMD_ERR;
          if (frame[2] == COM_STATUS) begin
            // served codes: acknowledge, busy or any fault the bench picks
            code = (err != 8'h00) ? err : (pend != 8'h00) ? pend
                 : (script.size() > 0) ? script.pop_front() : ST_ACK;
            pend = 8'h00;
            sum = 8'h00 - (8'h02 + code + ST_ACK);
            resp = {FRAME_STX, 8'h02, code, ST_ACK, sum, FRAME_ETX};
          end else begin
            pend = err;
          end
          frame.delete();
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/cfps_sequencer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cfps_sequencer_chk (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire logic                      start,
  input wire cfps_pkg::cfps_cmd_type    cmd_sel,
  input wire logic                      busy,
  input wire logic                      done,
  input wire cfps_pkg::cfps_result_type result,
  input wire logic [7:0]                primary_status_code,
  input wire logic [4:0]                attempt_count,
  input wire logic                      sck,
  input wire logic                      so,
  input wire logic                      si
);
  import cfps_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  cfps_cmd_type cmd_q; // command of the run in flight
  ////////////////////////////////////////
  // remember which command was accepted, the verdicts depend on it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CMD_STATUS;
    end else if (start && !busy) begin
      cmd_q <= cmd_sel;
    end
  end
  // one link clock half period, low then back high
  sequence sck_low_seq;
    (!sck) [*4] ##1 sck;
  endsequence
  sequence sck_high_seq;
    sck [*4];
  endsequence
  ////////////////////////////////////////
  start_taken_a: assert property (start && !busy |=> busy)
    else $error("request not taken");
  busy_cause_a: assert property ($rose(busy) |-> $past(start))
    else $error("busy without request");
  done_pulse_a: assert property (done |-> !busy ##1 !done)
    else $error("done not a single pulse");
  ack_normal_a: assert property (done && primary_status_code == ST_ACK |-> result == RES_NORMAL)
    else $error("acknowledge not normal");
  busy_timeout_a: assert property (done && primary_status_code == ST_BUSY |-> result == RES_TIMEOUT)
    else $error("busy end not time-out");
  fault_abort_a: assert property (done && primary_status_code != ST_ACK
    && primary_status_code != ST_BUSY |-> result == RES_ABNORMAL)
    else $error("fault code not abnormal");
  verdict_hold_a: assert property (!done |-> $stable(result))
    else $error("result moved between runs");
  reset_cap_a: assert property (done && cmd_q == CMD_RESET && result == RES_ABNORMAL
    |-> attempt_count == 5'h10)
    else $error("reset gave up early or late");
  single_try_a: assert property (done && cmd_q != CMD_RESET |-> attempt_count == 5'h01)
    else $error("non-reset command retried");
  sck_low_a: assert property ($fell(sck) |-> sck_low_seq)
    else $error("link clock low time wrong");
  sck_high_a: assert property ($rose(sck) |-> sck_high_seq)
    else $error("link clock high time short");
  link_quiet_a: assert property (!busy |-> sck)
    else $error("link clock active while idle");
endmodule
`default_nettype wire

// ===== verification/csi_flash_prog_cmd_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module csi_flash_prog_cmd_sequencer_tb;
  import cfps_pkg::*;
  logic            mclk;                // 20 MHz clock
  logic            rst_n;               // active-low reset
  logic            start;               // request strobe
  cfps_cmd_type    cmd_sel;             // requested command
  logic            busy;
  logic            done;
  cfps_result_type result;
  logic [7:0]      primary_status_code;
  logic [4:0]      attempt_count;
  logic            sck;
  logic            so;
  logic            si;
  int              errors;
  int              n_checks;
  int              seed;
  int              cycles = 0;          // watchdog count
  logic [7:0]      q[$];                // codes for the next run
  logic [7:0]      faults[10] = '{ST_CMD_ERR, ST_PARAM_ERR, ST_SUM_ERR, ST_VERIFY_ERR,
    ST_PROTECT_ERR, ST_NACK, ST_MODE_PIN_WRITE_FAULT, ST_ERASE_MARGIN_FAULT,
    ST_VERIFY_MARGIN_FAULT, ST_WRITE_ERR};
  // short waits keep the 16-attempt run brief; only the reset limit is cut, to reach
  // the time-out, while the other limits stay long and outlast any busy script
  cfps_sequencer #(.COMMAND_SPACING_US(1), .STATUS_FRAME_DELAY_US(1),
    .RESET_RESPONSE_DELAY_US(1), .FREQ_SET_RESPONSE_DELAY_US(1),
    .RESET_LIMIT_US(100)) i_cfps_sequencer (.mclk(mclk),
    .rst_n(rst_n), .start(start), .cmd_sel(cmd_sel), .busy(busy), .done(done),
    .result(result), .primary_status_code(primary_status_code),
    .attempt_count(attempt_count), .sck(sck), .so(so), .si(si));
  cfps_flash_dev i_cfps_flash_dev (.sck(sck), .so(so), .si(si));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////
  // cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  // run one command against the codes in q and predict the outcome
  task automatic run(input cfps_cmd_type c);
    int              i;
    int              att;
    int              n;
    logic [7:0]      code;
    cfps_result_type r;
    i = 0;
    att = 1;
    n = 0;
    i_cfps_flash_dev.script = q;
    @(posedge mclk);
    start <= 1'b1;
    cmd_sel <= c;
    @(posedge mclk);
    start <= 1'b0;
    while (done !== 1'b1 && n < 30000) begin
      @(posedge mclk);
      n++;
      // a request in mid-run and a wandering selector must be ignored
      start <= (n == 10);
      cmd_sel <= cfps_cmd_type'(2'({$random(seed)} % 4));
    end
    forever begin
      code = q[i];
      while (code == ST_BUSY && i + 1 < q.size()) begin
        i++;
        code = q[i];
      end
      if (code == ST_BUSY && c == CMD_RESET) begin
        r = RES_TIMEOUT;
        break;
      end
      // long limits: the script runs dry first and the device then answers ack
      if (code == ST_BUSY) code = ST_ACK;
      if (code == ST_ACK) begin
        r = RES_NORMAL;
        break;
      end
      if (c != CMD_RESET || att == 16) begin
        r = RES_ABNORMAL;
        break;
      end
      att++;
      i++;
    end
    check("result", 8'(result), 8'(r));
    check("status code", primary_status_code, code);
    check("attempts", 8'(attempt_count), 8'(att));
    check("busy", 8'(busy), 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 43056;
    errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    start = 1'b0;
    cmd_sel = CMD_STATUS;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check("idle clock", 8'(sck), 8'h01);
    q = {ST_ACK};
    run(CMD_STATUS);
    foreach (faults[k]) begin
      q = {faults[k]};
      run(CMD_STATUS);
    end
    q = {ST_BUSY, ST_ACK};
    run(CMD_STATUS);
    q = {ST_BUSY, ST_BUSY, ST_BUSY, ST_BUSY, ST_BUSY, ST_BUSY, ST_BUSY};
    run(CMD_STATUS);
    run(CMD_FREQ_SET);
    q = {ST_NACK, q};
    run(CMD_RESET);
    q = {ST_ACK};
    run(CMD_RESET);
    run(CMD_FREQ_SET);
    q = {ST_NACK, ST_SUM_ERR, ST_ACK};
    run(CMD_RESET);
    q = {};
    repeat (17) q.push_back(ST_NACK);
    run(CMD_RESET);
    q = {ST_PARAM_ERR};
    run(CMD_FREQ_SET);
    repeat (4) begin
      q = {faults[{$random(seed)} % 10], ST_ACK};
      run(cfps_cmd_type'(2'({$random(seed)} % 4)));
    end
    close_out();
  end
endmodule
bind cfps_sequencer cfps_sequencer_chk i_cfps_sequencer_chk (.mclk(mclk), .rst_n(rst_n),
  .start(start), .cmd_sel(cmd_sel), .busy(busy), .done(done), .result(result),
  .primary_status_code(primary_status_code), .attempt_count(attempt_count),
  .sck(sck), .so(so), .si(si));
`default_nettype wire
